/* hw/itex_params.svh */
/*
  Constants for the instruction timing and execution core: phase numbers,
  reset values and the data address that aliases the program counter.
  Assumes inclusion by bare name from the core and its package users.
*/
`ifndef ITEX_PARAMS_SVH
`define ITEX_PARAMS_SVH

`define ITEX_CLKS_PER_ICYC 4
`define ITEX_PH_FETCH 2'h0
`define ITEX_PH_DECODE 2'h1
`define ITEX_PH_EXEC 2'h2
`define ITEX_PH_WRITE 2'h3
`define ITEX_PC_LOW_ADDR 8'h02
`define ITEX_PC_RST 8'h00
`define ITEX_ACC_RST 8'h00
`define ITEX_OP_LSB 11
`define ITEX_BIT_LSB 8
`define ITEX_DST_BIT 8

`endif

/* hw/itex_pkg.sv */
/*
  Types of the instruction timing and execution core: opcodes and the
  sequencer states. Assumes nothing of its surroundings.
*/
package itex_pkg;

  typedef enum logic [4:0] {
    ITEX_NOP = 5'h00, ITEX_MOV_AM = 5'h01, ITEX_MOV_MA = 5'h02, ITEX_MOV_AI = 5'h03,
    ITEX_ADD_M = 5'h04, ITEX_ADD_I = 5'h05, ITEX_SUB_M = 5'h06, ITEX_SUB_I = 5'h07,
    ITEX_AND_M = 5'h08, ITEX_OR_M = 5'h09, ITEX_XOR_M = 5'h0a, ITEX_AND_I = 5'h0b,
    ITEX_OR_I = 5'h0c, ITEX_XOR_I = 5'h0d, ITEX_INVERT = 5'h0e, ITEX_INC = 5'h0f,
    ITEX_DEC = 5'h10, ITEX_ROT_R = 5'h11, ITEX_ROT_L = 5'h12, ITEX_ROT_RC = 5'h13,
    ITEX_ROT_LC = 5'h14, ITEX_BIT_CLR = 5'h15, ITEX_BIT_SET = 5'h16, ITEX_SKIP_Z = 5'h17,
    ITEX_SKIP_BZ = 5'h18, ITEX_SKIP_BNZ = 5'h19, ITEX_JUMP = 5'h1a, ITEX_CALL = 5'h1b,
    ITEX_SUB_EXIT = 5'h1c, ITEX_INT_EXIT = 5'h1d, ITEX_TAB_RD = 5'h1e, ITEX_SLEEP_OP = 5'h1f
  } itex_op_t;

  typedef enum logic [1:0] {
    ITEX_RUN = 2'b00,
    ITEX_FLUSH = 2'b01,
    ITEX_DOWN = 2'b11
  } itex_state_t;

endpackage : itex_pkg

/* hw/itex_core.sv */
/*
  Instruction timing and execution core of an 8-bit controller.
  Assumes an asynchronous-read program memory on PROG_ADDR/PROG_DATA and a
  data memory whose read data follows DMEM_ADDR within the same clock.
*/
// Function
// - One instruction cycle is four clocks and sequencing advances per whole cycle.
// - Jumps, calls, both returns and table reads take two instruction cycles.
// - A write to the program counter low byte costs one extra instruction cycle.
// - A skip costs one cycle when not taken and one more when taken.
// - Logical operations set the zero flag exactly when their result is zero.
// - Rotates move one bit; through-carry forms swap the shifted-out bit with carry.
// - A call saves the next address, a return resumes there, a jump saves nothing.
// - Conditional branches test a byte or a bit and then run or skip the next word.
// - Bit set and clear change only the selected bit in one instruction.
// - Add flags a carry above 255 and subtract flags a borrow below 0.
// - Increment and decrement change the operand by one into memory or accumulator.
// - Moves exist from memory to accumulator, back, and immediate to accumulator.
// - Results go to the accumulator or to the addressed byte; memory is never combined with memory.
// - A table read copies the low byte of the program word addressed by the accumulator into data memory in two cycles.
// - The sleep instruction stops execution and enters power-down.
`timescale 1ns/100ps
`include "itex_params.svh"

module itex_core #(
  parameter int STK_DEPTH = 4,
  parameter int SPW = 2
) (
  input wire logic CLK, // System clock, 250 MHz
  input wire logic RST_B, // Asynchronous reset, active low
  output logic [7:0] PROG_ADDR, // Program memory word address
  input wire logic [15:0] PROG_DATA, // Program memory word
  output logic [7:0] DMEM_ADDR, // Data memory address
  input wire logic [7:0] DMEM_RDATA, // Data memory read data
  output logic [7:0] DMEM_WDATA, // Data memory write data
  output logic DMEM_WE, // Data memory write strobe
  output logic [7:0] ACC, // Accumulator
  output logic ZERO_FLAG, // Zero flag
  output logic CARRY_FLAG, // Carry or borrow flag
  output logic INT_ENABLE, // Set by the interrupt exit
  output logic POWER_DOWN // Execution stopped
);

  logic [1:0] ph_reg;
  itex_pkg::itex_state_t state_reg;
  logic [7:0] pc_reg;
  logic [15:0] ir_reg;
  logic [7:0] acc_reg;
  logic zf_reg, cf_reg, ie_reg;
  logic [SPW-1:0] sp_reg;
  logic [7:0] stk_mem [STK_DEPTH];
  logic [7:0] paddr_reg, daddr_reg, wdata_reg;
  logic we_reg;

  itex_pkg::itex_op_t op;
  logic [2:0] bsel;
  logic to_mem;
  logic [7:0] fld, opnd, mask, res;
  logic [8:0] wide;
  logic wr_acc, wr_mem, upd_z, nc, skip, long_op, pc_low_wr, exec_now;

  assign op = itex_pkg::itex_op_t'(ir_reg[15:`ITEX_OP_LSB]);
  assign bsel = ir_reg[`ITEX_BIT_LSB+2:`ITEX_BIT_LSB];
  assign to_mem = ir_reg[`ITEX_DST_BIT];
  assign fld = ir_reg[7:0];
  // The program counter low byte reads back as the current word address
  assign opnd = (fld == `ITEX_PC_LOW_ADDR) ? pc_reg : DMEM_RDATA;
  assign mask = 8'h01 << bsel;
  assign exec_now = (state_reg == itex_pkg::ITEX_RUN) && (ph_reg == `ITEX_PH_EXEC);
  assign pc_low_wr = wr_mem && (fld == `ITEX_PC_LOW_ADDR);

  // Instruction decode and ALU; every byte result targets acc or one memory byte
  always_comb
  begin
    wide = 9'h000;
    res = acc_reg;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    upd_z = 1'b0;
    nc = cf_reg;
    skip = 1'b0;
    long_op = 1'b0;
    case (op)
      itex_pkg::ITEX_MOV_AM:
      begin
        res = opnd;
        wr_acc = 1'b1;
      end
      itex_pkg::ITEX_MOV_MA:
      begin
        res = acc_reg;
        wr_mem = 1'b1;
      end
      itex_pkg::ITEX_MOV_AI:
      begin
        res = fld;
        wr_acc = 1'b1;
      end
      itex_pkg::ITEX_ADD_M, itex_pkg::ITEX_ADD_I:
      begin
        wide = {1'b0, acc_reg} + {1'b0, (op == itex_pkg::ITEX_ADD_I) ? fld : opnd};
        {nc, res} = wide;
        upd_z = 1'b1;
        wr_mem = (op == itex_pkg::ITEX_ADD_M) && to_mem;
        wr_acc = !wr_mem;
      end
      itex_pkg::ITEX_SUB_M, itex_pkg::ITEX_SUB_I:
      begin
        wide = {1'b0, acc_reg} - {1'b0, (op == itex_pkg::ITEX_SUB_I) ? fld : opnd};
        {nc, res} = wide;
        upd_z = 1'b1;
        wr_mem = (op == itex_pkg::ITEX_SUB_M) && to_mem;
        wr_acc = !wr_mem;
      end
      itex_pkg::ITEX_AND_M, itex_pkg::ITEX_OR_M, itex_pkg::ITEX_XOR_M:
      begin
        res = (op == itex_pkg::ITEX_AND_M) ? (acc_reg & opnd) :
              (op == itex_pkg::ITEX_OR_M) ? (acc_reg | opnd) : (acc_reg ^ opnd);
        upd_z = 1'b1;
        wr_mem = to_mem;
        wr_acc = !to_mem;
      end
      itex_pkg::ITEX_AND_I, itex_pkg::ITEX_OR_I, itex_pkg::ITEX_XOR_I:
      begin
        res = (op == itex_pkg::ITEX_AND_I) ? (acc_reg & fld) :
              (op == itex_pkg::ITEX_OR_I) ? (acc_reg | fld) : (acc_reg ^ fld);
        upd_z = 1'b1;
        wr_acc = 1'b1;
      end
      itex_pkg::ITEX_INVERT:
      begin
        res = ~opnd;
        upd_z = 1'b1;
        wr_mem = to_mem;
        wr_acc = !to_mem;
      end
      itex_pkg::ITEX_INC, itex_pkg::ITEX_DEC:
      begin
        res = (op == itex_pkg::ITEX_INC) ? opnd + 8'h01 : opnd - 8'h01;
        upd_z = 1'b1;
        wr_mem = to_mem;
        wr_acc = !to_mem;
      end
      itex_pkg::ITEX_ROT_R, itex_pkg::ITEX_ROT_L, itex_pkg::ITEX_ROT_RC, itex_pkg::ITEX_ROT_LC:
      begin
        case (op)
          itex_pkg::ITEX_ROT_R: res = {opnd[0], opnd[7:1]};
          itex_pkg::ITEX_ROT_L: res = {opnd[6:0], opnd[7]};
          itex_pkg::ITEX_ROT_RC: {res, nc} = {cf_reg, opnd};
          default: {nc, res} = {opnd, cf_reg};
        endcase
        wr_mem = to_mem;
        wr_acc = !to_mem;
      end
      itex_pkg::ITEX_BIT_CLR:
      begin
        res = opnd & ~mask;
        wr_mem = 1'b1;
      end
      itex_pkg::ITEX_BIT_SET:
      begin
        res = opnd | mask;
        wr_mem = 1'b1;
      end
      itex_pkg::ITEX_SKIP_Z: skip = (opnd == 8'h00);
      itex_pkg::ITEX_SKIP_BZ: skip = ((opnd & mask) == 8'h00);
      itex_pkg::ITEX_SKIP_BNZ: skip = ((opnd & mask) != 8'h00);
      itex_pkg::ITEX_JUMP, itex_pkg::ITEX_CALL, itex_pkg::ITEX_SUB_EXIT,
      itex_pkg::ITEX_INT_EXIT, itex_pkg::ITEX_TAB_RD: long_op = 1'b1;
      default: res = acc_reg;
    endcase
  end

  // Four-clock instruction cycle
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      ph_reg <= `ITEX_PH_FETCH;
    else
      ph_reg <= ph_reg + 2'h1;
  end

  // Sequencer: a flush cycle spans phase 3 of the instruction through phase 2 of the next
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_reg <= itex_pkg::ITEX_RUN;
      pc_reg <= `ITEX_PC_RST;
    end
    else if (exec_now)
    begin
      if (op == itex_pkg::ITEX_SLEEP_OP)
        state_reg <= itex_pkg::ITEX_DOWN;
      else if (long_op || pc_low_wr || skip)
        state_reg <= itex_pkg::ITEX_FLUSH;
      if (op == itex_pkg::ITEX_JUMP || op == itex_pkg::ITEX_CALL)
        pc_reg <= fld;
      else if (op == itex_pkg::ITEX_SUB_EXIT || op == itex_pkg::ITEX_INT_EXIT)
        pc_reg <= stk_mem[sp_reg - 1'b1];
      else if (pc_low_wr)
        pc_reg <= res;
      else if (skip)
        pc_reg <= pc_reg + 8'h02;
      else if (op != itex_pkg::ITEX_SLEEP_OP)
        pc_reg <= pc_reg + 8'h01;
    end
    else if (state_reg == itex_pkg::ITEX_FLUSH && ph_reg == `ITEX_PH_EXEC)
      state_reg <= itex_pkg::ITEX_RUN;
  end

  // Return stack; a full stack wraps and overwrites the oldest entry
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      sp_reg <= '0;
    else if (exec_now && op == itex_pkg::ITEX_CALL)
      sp_reg <= sp_reg + 1'b1;
    else if (exec_now && (op == itex_pkg::ITEX_SUB_EXIT || op == itex_pkg::ITEX_INT_EXIT))
      sp_reg <= sp_reg - 1'b1;
  end

  always_ff @(posedge CLK)
  begin
    if (exec_now && op == itex_pkg::ITEX_CALL)
      stk_mem[sp_reg] <= pc_reg + 8'h01;
  end

  // Accumulator and flags
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      acc_reg <= `ITEX_ACC_RST;
      zf_reg <= 1'b0;
      cf_reg <= 1'b0;
      ie_reg <= 1'b0;
    end
    else if (exec_now)
    begin
      if (wr_acc)
        acc_reg <= res;
      if (upd_z)
        zf_reg <= (res == 8'h00);
      cf_reg <= nc;
      if (op == itex_pkg::ITEX_INT_EXIT)
        ie_reg <= 1'b1;
    end
  end

  // Bus side: fetch in phase 0, decode in phase 1, write strobe one clock
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ir_reg <= 16'h0000;
      paddr_reg <= `ITEX_PC_RST;
      daddr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      we_reg <= 1'b0;
    end
    else
    begin
      we_reg <= 1'b0;
      if (ph_reg == `ITEX_PH_FETCH)
        paddr_reg <= (state_reg == itex_pkg::ITEX_FLUSH && op == itex_pkg::ITEX_TAB_RD) ?
                     acc_reg : pc_reg;
      if (ph_reg == `ITEX_PH_DECODE && state_reg == itex_pkg::ITEX_RUN)
      begin
        ir_reg <= PROG_DATA;
        daddr_reg <= PROG_DATA[7:0];
      end
      if (ph_reg == `ITEX_PH_DECODE && state_reg == itex_pkg::ITEX_FLUSH &&
          op == itex_pkg::ITEX_TAB_RD)
      begin
        wdata_reg <= PROG_DATA[7:0];
        we_reg <= 1'b1;
      end
      if (exec_now && wr_mem && !pc_low_wr)
      begin
        wdata_reg <= res;
        we_reg <= 1'b1;
      end
    end
  end

  assign PROG_ADDR = paddr_reg;
  assign DMEM_ADDR = daddr_reg;
  assign DMEM_WDATA = wdata_reg;
  assign DMEM_WE = we_reg;
  assign ACC = acc_reg;
  assign ZERO_FLAG = zf_reg;
  assign CARRY_FLAG = cf_reg;
  assign INT_ENABLE = ie_reg;
  assign POWER_DOWN = (state_reg == itex_pkg::ITEX_DOWN);

  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sequence long_start_s;
    exec_now && long_op;
  endsequence
  sequence one_flush_s;
    (state_reg == itex_pkg::ITEX_FLUSH) [*4] ##1 (state_reg == itex_pkg::ITEX_RUN);
  endsequence

  phase_step_a: assert property (ph_reg == 2'h3 |=> ph_reg == 2'h0)
    else $error("phase did not wrap after four clocks");
  long_two_cycles_a: assert property (long_start_s |=> one_flush_s)
    else $error("long instruction did not take one flush cycle");
  pc_low_extra_a: assert property (exec_now && pc_low_wr |=> one_flush_s)
    else $error("pc low byte write did not add a cycle");
  skip_taken_a: assert property (exec_now && skip |=>
      pc_reg == $past(pc_reg) + 8'h02 && state_reg == itex_pkg::ITEX_FLUSH)
    else $error("taken skip wrong");
  skip_not_taken_a: assert property (exec_now && !skip &&
      op inside {itex_pkg::ITEX_SKIP_Z, itex_pkg::ITEX_SKIP_BZ, itex_pkg::ITEX_SKIP_BNZ}
      |=> pc_reg == $past(pc_reg) + 8'h01 && state_reg == itex_pkg::ITEX_RUN)
    else $error("untaken skip wrong");
  zero_flag_a: assert property (exec_now && upd_z |=> zf_reg == ($past(res) == 8'h00))
    else $error("zero flag wrong");
  rotate_carry_a: assert property (exec_now && op == itex_pkg::ITEX_ROT_LC |=>
      cf_reg == $past(opnd[7]))
    else $error("rotate left through carry lost bit");
  call_push_a: assert property (exec_now && op == itex_pkg::ITEX_CALL |=>
      stk_mem[sp_reg - 1'b1] == $past(pc_reg) + 8'h01)
    else $error("call saved wrong return address");
  bit_set_a: assert property (exec_now && op == itex_pkg::ITEX_BIT_SET |=>
      DMEM_WE && DMEM_WDATA == ($past(opnd) | $past(mask)))
    else $error("bit set changed other bits");
  add_carry_a: assert property (exec_now && op == itex_pkg::ITEX_ADD_I |=>
      cf_reg == (({1'b0, $past(acc_reg)} + {1'b0, $past(fld)}) > 9'h0ff))
    else $error("add carry wrong");
  power_down_a: assert property (POWER_DOWN |=> POWER_DOWN && $stable(pc_reg))
    else $error("execution resumed after sleep");

endmodule : itex_core

/* test/itex_mem_model.sv */
/*
  Program and data memory seen by the execution core: a program store and a
  data store, both read asynchronously, the data store written on the strobe.
  Assumes the bench fills both stores through hierarchy before or while reset is held.
*/
`timescale 1ns/100ps

module itex_mem_model (
  input wire logic CLK, // System clock
  input wire logic [7:0] PROG_ADDR, // Program word address
  output logic [15:0] PROG_DATA, // Program word
  input wire logic [7:0] DMEM_ADDR, // Data address
  output logic [7:0] DMEM_RDATA, // Data read value
  input wire logic [7:0] DMEM_WDATA, // Data write value
  input wire logic DMEM_WE // Data write strobe
);
  logic [15:0] prog [0:255];
  logic [7:0] dmem [0:255];

  // Reads follow the address at once, as the core samples them a clock later
  assign PROG_DATA = prog[PROG_ADDR];
  assign DMEM_RDATA = dmem[DMEM_ADDR];

  always @(posedge CLK)
  begin
    if (DMEM_WE === 1'b1)
    begin
      dmem[DMEM_ADDR] <= DMEM_WDATA;
    end
  end
endmodule : itex_mem_model

/* test/itex_core_bench.sv */
/*
  Self-checking bench of the execution core: short programs run from reset
  to the sleep instruction; every data write is logged with time and flags.
  Assumes the instruction layout and phase timing of the core's hand-over.
*/
`timescale 1ns/100ps

module itex_core_bench;
  logic clk;
  logic rst_b;
  logic [7:0] prog_addr;
  logic [15:0] prog_data;
  logic [7:0] dmem_addr;
  logic [7:0] dmem_rdata;
  logic [7:0] dmem_wdata;
  logic dmem_we;
  logic [7:0] acc;
  logic zero_flag;
  logic carry_flag;
  logic int_enable;
  logic power_down;
  int num_errors;
  int checks_done;
  int cyc;
  logic [33:0] wlog [$];

  itex_core itex_core_i (.CLK(clk), .RST_B(rst_b), .PROG_ADDR(prog_addr),
    .PROG_DATA(prog_data), .DMEM_ADDR(dmem_addr), .DMEM_RDATA(dmem_rdata),
    .DMEM_WDATA(dmem_wdata), .DMEM_WE(dmem_we), .ACC(acc), .ZERO_FLAG(zero_flag),
    .CARRY_FLAG(carry_flag), .INT_ENABLE(int_enable), .POWER_DOWN(power_down));

  itex_mem_model itex_mem_model_i (.CLK(clk), .PROG_ADDR(prog_addr),
    .PROG_DATA(prog_data), .DMEM_ADDR(dmem_addr), .DMEM_RDATA(dmem_rdata),
    .DMEM_WDATA(dmem_wdata), .DMEM_WE(dmem_we));

  always #2 clk = ~clk;

  // Log entry: cycle, address, data, zero, carry; flags already hold this result
  always @(posedge clk)
  begin
    if (dmem_we === 1'b1)
    begin
      wlog.push_back({cyc[15:0], dmem_addr, dmem_wdata, zero_flag, carry_flag});
    end
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      num_errors++;
      finish_test();
    end
  end

  function automatic logic [15:0] w(input itex_pkg::itex_op_t op, input logic [2:0] b,
    input logic [7:0] a);
    return {op, b, a};
  endfunction : w

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Reset is held for 5 cycles while the program is loaded, then runs to sleep
  task automatic run(input logic [15:0] p [$]);
    @(posedge clk);
    #1 rst_b = 1'b0;
    wlog.delete();
    // Only the program words are loaded, so table data placed beforehand survives
    for (int i = 0; i < p.size(); i++)
    begin
      itex_mem_model_i.prog[i] = p[i];
    end
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    for (int n = 0; n < 400 && power_down !== 1'b1; n++)
    begin
      @(posedge clk);
      #1;
    end
    check({33'h0, power_down}, 34'h1);
    repeat (8) @(posedge clk);
    #1;
  endtask : run

  task automatic chk_log(input logic [17:0] e [$]);
    check(34'(wlog.size()), 34'(e.size()));
    for (int i = 0; i < e.size(); i++)
    begin
      check({16'h0, wlog[i][17:0]}, {16'h0, e[i]});
    end
  endtask : chk_log

  task automatic chk_gap(input int i, input logic [15:0] exp);
    check({18'h0, wlog[i][33:18] - wlog[i - 1][33:18]}, {18'h0, exp});
  endtask : chk_gap

  task automatic t_branch;
    run('{w(itex_pkg::ITEX_MOV_AI, 3'h0, 8'h05), w(itex_pkg::ITEX_MOV_MA, 3'h1, 8'h20),
      w(itex_pkg::ITEX_JUMP, 3'h0, 8'h04), w(itex_pkg::ITEX_MOV_MA, 3'h1, 8'h2f),
      w(itex_pkg::ITEX_MOV_MA, 3'h1, 8'h21), w(itex_pkg::ITEX_CALL, 3'h0, 8'h09),
      w(itex_pkg::ITEX_MOV_MA, 3'h1, 8'h22), w(itex_pkg::ITEX_SLEEP_OP, 3'h0, 8'h00),
      w(itex_pkg::ITEX_NOP, 3'h0, 8'h00), w(itex_pkg::ITEX_MOV_MA, 3'h1, 8'h23),
      w(itex_pkg::ITEX_SUB_EXIT, 3'h0, 8'h00)});
    chk_log('{{8'h20, 8'h05, 2'h0}, {8'h21, 8'h05, 2'h0}, {8'h23, 8'h05, 2'h0},
      {8'h22, 8'h05, 2'h0}});
    chk_gap(1, 16'd12);
    chk_gap(2, 16'd12);
    chk_gap(3, 16'd12);
    check({33'h0, int_enable}, 34'h0);
  endtask : t_branch

  task automatic t_skip;
    run('{w(itex_pkg::ITEX_MOV_MA, 3'h1, 8'h30), w(itex_pkg::ITEX_SKIP_Z, 3'h0, 8'h30),
      w(itex_pkg::ITEX_MOV_MA, 3'h1, 8'h3f), w(itex_pkg::ITEX_MOV_MA, 3'h1, 8'h31),
      w(itex_pkg::ITEX_SKIP_BNZ, 3'h0, 8'h30), w(itex_pkg::ITEX_SKIP_BZ, 3'h2, 8'h30),
      w(itex_pkg::ITEX_MOV_MA, 3'h1, 8'h3f), w(itex_pkg::ITEX_MOV_MA, 3'h1, 8'h32),
      w(itex_pkg::ITEX_MOV_AI, 3'h0, 8'h0c), w(itex_pkg::ITEX_MOV_MA, 3'h1, 8'h02),
      w(itex_pkg::ITEX_MOV_MA, 3'h1, 8'h3e), w(itex_pkg::ITEX_MOV_MA, 3'h1, 8'h3e),
      w(itex_pkg::ITEX_MOV_MA, 3'h1, 8'h33), w(itex_pkg::ITEX_CALL, 3'h0, 8'h0f),
      w(itex_pkg::ITEX_SLEEP_OP, 3'h0, 8'h00), w(itex_pkg::ITEX_INT_EXIT, 3'h0, 8'h00)});
    chk_log('{{8'h30, 8'h00, 2'h0}, {8'h31, 8'h00, 2'h0}, {8'h32, 8'h00, 2'h0},
      {8'h33, 8'h0c, 2'h0}});
    chk_gap(1, 16'd12);
    chk_gap(2, 16'd16);
    chk_gap(3, 16'd16);
    check({33'h0, int_enable}, 34'h1);
  endtask : t_skip

  // Results go to a log address so the flags can be seen right after each step
  task automatic t_alu;
    itex_mem_model_i.dmem[8'h40] = 8'hf0;
    itex_mem_model_i.dmem[8'h41] = 8'h00;
    itex_mem_model_i.dmem[8'h42] = 8'h81;
    itex_mem_model_i.dmem[8'h43] = 8'hff;
    run('{w(itex_pkg::ITEX_MOV_AI, 3'h0, 8'hf0), w(itex_pkg::ITEX_AND_M, 3'h0, 8'h41),
      w(itex_pkg::ITEX_MOV_MA, 3'h1, 8'h50), w(itex_pkg::ITEX_OR_I, 3'h0, 8'h81),
      w(itex_pkg::ITEX_ADD_M, 3'h0, 8'h42), w(itex_pkg::ITEX_MOV_MA, 3'h1, 8'h51),
      w(itex_pkg::ITEX_SUB_I, 3'h0, 8'h03), w(itex_pkg::ITEX_XOR_M, 3'h0, 8'h43),
      w(itex_pkg::ITEX_MOV_MA, 3'h1, 8'h52), w(itex_pkg::ITEX_ROT_RC, 3'h1, 8'h42),
      w(itex_pkg::ITEX_ROT_LC, 3'h1, 8'h40), w(itex_pkg::ITEX_ROT_L, 3'h1, 8'h42),
      w(itex_pkg::ITEX_ROT_R, 3'h1, 8'h40), w(itex_pkg::ITEX_INC, 3'h1, 8'h43),
      w(itex_pkg::ITEX_DEC, 3'h0, 8'h43), w(itex_pkg::ITEX_BIT_SET, 3'h3, 8'h41),
      w(itex_pkg::ITEX_BIT_CLR, 3'h7, 8'h40), w(itex_pkg::ITEX_MOV_MA, 3'h1, 8'h53),
      w(itex_pkg::ITEX_INVERT, 3'h1, 8'h41), w(itex_pkg::ITEX_MOV_AM, 3'h0, 8'h41),
      w(itex_pkg::ITEX_ADD_I, 3'h0, 8'h08), w(itex_pkg::ITEX_SUB_M, 3'h0, 8'h40),
      w(itex_pkg::ITEX_MOV_MA, 3'h1, 8'h54), w(itex_pkg::ITEX_SLEEP_OP, 3'h0, 8'h00)});
    chk_log('{{8'h50, 8'h00, 2'h2}, {8'h51, 8'h02, 2'h1}, {8'h52, 8'h00, 2'h3},
      {8'h42, 8'hc0, 2'h3}, {8'h40, 8'he1, 2'h3}, {8'h42, 8'h81, 2'h3},
      {8'h40, 8'hf0, 2'h3}, {8'h43, 8'h00, 2'h3}, {8'h41, 8'h08, 2'h1},
      {8'h40, 8'h70, 2'h1}, {8'h53, 8'hff, 2'h1}, {8'h41, 8'hf7, 2'h1},
      {8'h54, 8'h8f, 2'h0}});
    check({26'h0, acc}, 34'h8f);
  endtask : t_alu

  task automatic t_table;
    itex_mem_model_i.prog[8'h60] = 16'hab5c;
    run('{w(itex_pkg::ITEX_MOV_AI, 3'h0, 8'h60), w(itex_pkg::ITEX_TAB_RD, 3'h0, 8'h70),
      w(itex_pkg::ITEX_MOV_MA, 3'h1, 8'h71), w(itex_pkg::ITEX_SLEEP_OP, 3'h0, 8'h00),
      w(itex_pkg::ITEX_NOP, 3'h0, 8'h00)});
    chk_log('{{8'h70, 8'h5c, 2'h0}, {8'h71, 8'h60, 2'h0}});
    chk_gap(1, 16'd5);
  endtask : t_table

  task finish_test;
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    num_errors = 0;
    checks_done = 0;
    cyc = 0;
    t_branch();
    t_skip();
    t_alu();
    t_table();
    finish_test();
  end
endmodule : itex_core_bench
